// File: core/wsc_pkg.sv
// Constants and types of the sector write command handler.
package wsc_pkg;

    // Task-file register selects on the register port.
    localparam logic [2:0] REG_DATA     = 3'h0;
    localparam logic [2:0] REG_FEATURE  = 3'h1;  // feature_input on write, error_report on read
    localparam logic [2:0] REG_COUNT    = 3'h2;
    localparam logic [2:0] REG_LOW      = 3'h3;
    localparam logic [2:0] REG_MID      = 3'h4;
    localparam logic [2:0] REG_HIGH     = 3'h5;
    localparam logic [2:0] REG_DEVICE   = 3'h6;
    localparam logic [2:0] REG_COMMAND  = 3'h7;  // command_opcode on write, status_report on read

    // The lowest opcode bit only asks for retries and is masked off.
    localparam logic [7:0] OPC_WRITE_SECTORS = 8'h30;
    localparam logic [7:0] OPC_RETRY_MASK    = 8'hfe;

    // Device register fields.
    localparam int DEV_MODE_BIT = 6;
    localparam int DEV_HEAD_MSB = 3;

    // Status register bit positions.
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_SEEK  = 4;
    localparam int ST_DRQ   = 3;
    localparam int ST_ERR   = 0;

    // Error register bit positions.
    localparam int ER_ID_NOT_FOUND = 4;
    localparam int ER_ABORTED      = 2;

    // Transfer sizes.
    localparam int          WORD_W           = 16;
    localparam int          FIFO_DEPTH       = 4;
    localparam logic [8:0]  ZERO_COUNT_SECTORS = 9'h100;
    localparam int          SECTOR_WORD_BITS = 8;  // 256 words of 16 bits per sector

    // Geometry used to step a cylinder/head/sector address.
    localparam logic [7:0] SECTORS_PER_TRACK = 8'h3f;
    localparam logic [3:0] LAST_HEAD         = 4'hf;

    // Values after reset.
    localparam logic [7:0] COUNT_RESET  = 8'h01;
    localparam logic [7:0] LOW_RESET    = 8'h01;
    localparam logic [7:0] MID_RESET    = 8'h00;
    localparam logic [7:0] HIGH_RESET   = 8'h00;
    localparam logic [7:0] ERROR_RESET  = 8'h00;

    typedef enum logic [1:0] {
        WSC_IDLE,
        WSC_XFER,
        WSC_FLUSH
    } wsc_state_t;

endpackage : wsc_pkg

// File: core/wsc_fifo.sv
// Word FIFO between the host data port and the media path.
module wsc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,  // system clock
    input  wire logic             reset,     // asynchronous, active high
    input  wire logic             flush,     // discards every stored word
    input  wire logic             in_valid,  // word offered
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // word in
    output logic                  out_valid, // head word present
    input  wire logic             out_ready, // consumer takes head word
    output logic [WIDTH-1:0]      out_data   // head word
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;
    logic [CW-1:0]    wr_pos;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign wr_pos   = CW'(count - CW'(pop));
    assign out_data = slot[0];

    always_comb begin
        if (flush) begin
            next_count = '0;
        end else begin
            next_count = CW'(count + CW'(push) - CW'(pop));
        end
    end

    // Slot 0 is the head, so the output word always comes from a register.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                slot[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && CW'(i) == wr_pos) begin
                    slot[i] <= in_data;
                end else if (pop && i + 1 < DEPTH) begin
                    slot[i] <= slot[i + 1];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count     <= next_count;
            in_ready  <= next_count < CW'(DEPTH);
            out_valid <= next_count != '0;
        end
    end

endmodule : wsc_fifo

// File: core/wsc_handler.sv
// Task-file registers and sequencing for the single-byte-count sector write command.

module wsc_handler
    import wsc_pkg::*;
(
    input  wire logic               core_clk,            // system clock, 50 MHz
    input  wire logic               reset,               // asynchronous, active high
    input  wire logic [2:0]         tf_addr,             // task-file register select
    input  wire logic               tf_write,            // write strobe, one cycle
    input  wire logic               tf_read,             // read strobe, one cycle
    input  wire logic [WORD_W-1:0]  tf_wdata,            // write data, bytes in low lane
    output logic [WORD_W-1:0]       tf_rdata,            // read data, one cycle after strobe
    output logic                    data_request,        // device wants sector words
    output logic                    data_ready,          // buffer has room for a word
    output logic                    busy,                // command in progress, no data wanted
    output logic                    cmd_done,            // pulse when a command ends
    output logic [WORD_W-1:0]       media_word,          // word toward the media path
    output logic                    media_valid,         // media_word is valid
    input  wire logic               media_ready,         // media path takes the word
    output logic [27:0]             media_address,       // address of the sector in work
    output logic                    media_lba_mode,      // address form of media_address
    input  wire logic               media_done,          // pulse: current sector finished
    input  wire logic               media_uncorrectable, // with media_done: write failed
    input  wire logic               media_id_missing,    // with media_done: sector not found
    input  wire logic               media_fault,         // level: device fault
    input  wire logic               auto_reassign        // level: reassignment enabled
);

    wsc_state_t  state;
    wsc_state_t  next_state;

    logic [7:0]  feature_input;
    logic [7:0]  sector_count;
    logic [7:0]  address_low;
    logic [7:0]  address_mid;
    logic [7:0]  address_high;
    logic        lba_mode;
    logic [3:0]  head_field;
    logic [7:0]  error_report;
    logic        status_err;
    logic        status_fault;

    logic [8:0]  sectors_left;
    logic [16:0] words_left;
    logic [16:0] next_words_left;

    logic        cmd_write;
    logic        is_write_opcode;
    logic        start;
    logic        abort_cmd;
    logic        word_push;
    logic        sector_ok;
    logic        sector_fail;
    logic        id_fail;
    logic        last_sector;
    logic        fifo_flush;
    logic [27:0] cur_address;

    // Steps a sector address by one in either address form.
    function automatic logic [27:0] step_address(input logic       lba,
                                                 input logic [27:0] a);
        logic [7:0]  sec;
        logic [3:0]  head;
        logic [15:0] cyl;
        sec  = a[7:0];
        cyl  = a[23:8];
        head = a[27:24];
        if (lba) begin
            return 28'(a + 28'h1);
        end
        if (sec >= SECTORS_PER_TRACK) begin
            sec = 8'h01;
            if (head == LAST_HEAD) begin
                head = 4'h0;
                cyl  = 16'(cyl + 16'h1);
            end else begin
                head = 4'(head + 4'h1);
            end
        end else begin
            sec = 8'(sec + 8'h1);
        end
        return {head, cyl, sec};
    endfunction : step_address

    assign cur_address     = {head_field, address_high, address_mid, address_low};
    assign cmd_write       = tf_write && tf_addr == REG_COMMAND && state == WSC_IDLE;
    assign is_write_opcode = (tf_wdata[7:0] & OPC_RETRY_MASK) == OPC_WRITE_SECTORS;
    assign start           = cmd_write && is_write_opcode;
    assign abort_cmd       = cmd_write && !is_write_opcode;

    // A word is taken only while requested and the buffer has room.
    assign word_push = tf_write && tf_addr == REG_DATA && data_request && data_ready;

    assign id_fail     = state == WSC_XFER && media_done && media_id_missing;
    assign sector_fail = state == WSC_XFER && media_done && !media_id_missing
                         && media_uncorrectable && !auto_reassign;
    assign sector_ok   = state == WSC_XFER && media_done && !id_fail && !sector_fail;
    assign last_sector = sectors_left == 9'h001;
    assign fifo_flush  = state == WSC_FLUSH;

    always_comb begin
        next_words_left = words_left;
        if (start) begin
            next_words_left = {(sector_count == 8'h00) ? ZERO_COUNT_SECTORS
                                                      : {1'b0, sector_count},
                               SECTOR_WORD_BITS'(0)};
        end else if (id_fail || sector_fail) begin
            next_words_left = '0;
        end else if (word_push) begin
            next_words_left = 17'(words_left - 17'h1);
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            WSC_IDLE: begin
                if (start) begin
                    next_state = WSC_XFER;
                end
            end
            WSC_XFER: begin
                if (id_fail || sector_fail) begin
                    next_state = WSC_FLUSH;
                end else if (sector_ok && last_sector) begin
                    next_state = WSC_IDLE;
                end
            end
            WSC_FLUSH: begin
                next_state = WSC_IDLE;
            end
            default: begin
                next_state = WSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state      <= WSC_IDLE;
            words_left <= '0;
        end else begin
            state      <= next_state;
            words_left <= next_words_left;
        end
    end

    // Handshake outputs; busy and data_request never show together.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            data_request <= 1'b0;
            busy         <= 1'b0;
            cmd_done     <= 1'b0;
        end else begin
            data_request <= next_state == WSC_XFER && next_words_left != '0;
            busy         <= next_state != WSC_IDLE && next_words_left == '0;
            cmd_done     <= (state != WSC_IDLE && next_state == WSC_IDLE) || abort_cmd;
        end
    end

    // Parameter writes are ignored while a command runs.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            feature_input <= 8'h00;
            lba_mode      <= 1'b0;
        end else if (tf_write && state == WSC_IDLE) begin
            if (tf_addr == REG_FEATURE) begin
                feature_input <= tf_wdata[7:0];
            end
            if (tf_addr == REG_DEVICE) begin
                lba_mode <= tf_wdata[DEV_MODE_BIT];
            end
        end
    end

    // Loaded by the host, then rewritten as sectors complete.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sector_count <= COUNT_RESET;
            address_low  <= LOW_RESET;
            address_mid  <= MID_RESET;
            address_high <= HIGH_RESET;
            head_field   <= 4'h0;
        end else if (state == WSC_IDLE) begin
            if (tf_write && tf_addr == REG_COUNT) begin
                sector_count <= tf_wdata[7:0];
            end
            if (tf_write && tf_addr == REG_LOW) begin
                address_low <= tf_wdata[7:0];
            end
            if (tf_write && tf_addr == REG_MID) begin
                address_mid <= tf_wdata[7:0];
            end
            if (tf_write && tf_addr == REG_HIGH) begin
                address_high <= tf_wdata[7:0];
            end
            if (tf_write && tf_addr == REG_DEVICE) begin
                head_field <= tf_wdata[DEV_HEAD_MSB:0];
            end
        end else if (sector_ok) begin
            sector_count <= 8'(sectors_left - 9'h001);
            if (!last_sector) begin
                {head_field, address_high, address_mid, address_low}
                    <= step_address(lba_mode, cur_address);
            end
        end else if (id_fail || sector_fail) begin
            // The failing sector is left in the address registers and still counted.
            sector_count <= sectors_left[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sectors_left <= '0;
        end else if (start) begin
            sectors_left <= (sector_count == 8'h00) ? ZERO_COUNT_SECTORS
                                                    : {1'b0, sector_count};
        end else if (sector_ok) begin
            sectors_left <= 9'(sectors_left - 9'h001);
        end
    end

    // Only the not-found and aborted error bits are ever raised.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            error_report <= ERROR_RESET;
            status_err   <= 1'b0;
        end else if (start) begin
            error_report <= ERROR_RESET;
            status_err   <= 1'b0;
        end else if (abort_cmd || sector_fail) begin
            error_report[ER_ABORTED] <= 1'b1;
            status_err               <= 1'b1;
        end else if (id_fail) begin
            error_report[ER_ID_NOT_FOUND] <= 1'b1;
            status_err                    <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_fault <= 1'b0;
        end else begin
            status_fault <= media_fault;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            media_address  <= '0;
            media_lba_mode <= 1'b0;
        end else begin
            media_address  <= cur_address;
            media_lba_mode <= lba_mode;
        end
    end

    // Register reads; corrected-data and index always read as zero.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tf_rdata <= '0;
        end else if (tf_read) begin
            tf_rdata <= '0;
            case (tf_addr)
                REG_FEATURE: tf_rdata[7:0] <= error_report;
                REG_COUNT:   tf_rdata[7:0] <= sector_count;
                REG_LOW:     tf_rdata[7:0] <= address_low;
                REG_MID:     tf_rdata[7:0] <= address_mid;
                REG_HIGH:    tf_rdata[7:0] <= address_high;
                REG_DEVICE:  tf_rdata[7:0] <= {1'b0, lba_mode, 2'b00, head_field};
                REG_COMMAND: begin
                    tf_rdata[ST_BUSY]  <= busy;
                    tf_rdata[ST_READY] <= 1'b1;
                    tf_rdata[ST_FAULT] <= status_fault;
                    tf_rdata[ST_SEEK]  <= 1'b1;
                    tf_rdata[ST_DRQ]   <= data_request;
                    tf_rdata[ST_ERR]   <= status_err;
                end
                default: tf_rdata <= '0;
            endcase
        end
    end

    // The buffer is emptied in WSC_FLUSH after a failed sector; until then its words are still offered to the media.
    wsc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .flush     (fifo_flush),
        .in_valid  (word_push),
        .in_ready  (data_ready),
        .in_data   (tf_wdata),
        .out_valid (media_valid),
        .out_ready (media_ready),
        .out_data  (media_word)
    );

endmodule : wsc_handler

// File: dv/wsc_handler_props.sv
// Concurrent checks on the ports of the sector write command handler.
module wsc_handler_props
    import wsc_pkg::*;
(
    input wire logic        core_clk,            // clock
    input wire logic        reset,               // async reset
    input wire logic [2:0]  tf_addr,             // register select
    input wire logic        tf_write,            // write strobe
    input wire logic        tf_read,             // read strobe
    input wire logic [15:0] tf_wdata,            // write data
    input wire logic [15:0] tf_rdata,            // read data
    input wire logic        data_request,        // words wanted
    input wire logic        busy,                // running
    input wire logic        cmd_done,            // end pulse
    input wire logic        media_done,          // sector end
    input wire logic        media_uncorrectable, // write failed
    input wire logic        media_id_missing,    // not found
    input wire logic        auto_reassign        // reassign on
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    wire good_opc = (tf_wdata[7:0] & OPC_RETRY_MASK) == OPC_WRITE_SECTORS;
    wire sec_fail = media_done && (media_id_missing || media_uncorrectable && !auto_reassign);

    sequence cmd_s(ok);
        tf_write && tf_addr == REG_COMMAND && !busy && !data_request && good_opc == ok;
    endsequence
    sequence wind_down_s;
        !data_request ##[0:1] (cmd_done && !busy);
    endsequence

    start_write_a: assert property (cmd_s(1'b1) |=> data_request)
        else $error("no transfer after write opcode");
    bad_opcode_a: assert property (cmd_s(1'b0) |=> cmd_done && !data_request)
        else $error("bad opcode not refused");
    error_stop_a: assert property (sec_fail && (busy || data_request) |=> wind_down_s)
        else $error("failed sector did not end run");
    req_busy_excl_a: assert property (!(data_request && busy))
        else $error("data request and busy together");
    words_end_a: assert property ($fell(data_request) |-> busy)
        else $error("request fell without busy");
    done_idle_a: assert property (cmd_done |-> !busy && !data_request)
        else $error("command end while still busy");
    done_pulse_a: assert property (cmd_done |=> !cmd_done)
        else $error("command end pulse too long");
    status_bits_a: assert property (tf_read && tf_addr == REG_COMMAND |=>
        tf_rdata[15:8] == 8'h00 && tf_rdata[ST_BUSY] == $past(busy) && tf_rdata[ST_READY]
        && tf_rdata[ST_SEEK] && tf_rdata[2:1] == 2'h0)
        else $error("bad status fixed bits");
    error_bits_a: assert property (tf_read && tf_addr == REG_FEATURE |=>
        (tf_rdata & 16'hffeb) == 16'h0000)
        else $error("forbidden error bit");
    device_bits_a: assert property (tf_read && tf_addr == REG_DEVICE |=>
        tf_rdata[15:7] == 9'h000 && tf_rdata[5:4] == 2'h0)
        else $error("device unused bits set");
endmodule : wsc_handler_props

bind wsc_handler wsc_handler_props u_props (
    .core_clk(core_clk), .reset(reset), .tf_addr(tf_addr), .tf_write(tf_write),
    .tf_read(tf_read), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
    .data_request(data_request), .busy(busy), .cmd_done(cmd_done), .media_done(media_done),
    .media_uncorrectable(media_uncorrectable), .media_id_missing(media_id_missing),
    .auto_reassign(auto_reassign)
);

// File: dv/wsc_media_model.sv
// Media write path model: takes words and reports each sector.
module wsc_media_model (
    input wire logic        core_clk,            // clock
    input wire logic        reset,               // async reset
    input wire logic [15:0] media_word,          // word in
    input wire logic        media_valid,         // word offered
    output logic            media_ready,         // word taken
    output logic            media_done,          // sector end pulse
    output logic            media_uncorrectable, // write failed
    output logic            media_id_missing,    // not found
    input wire logic        slow,                // stall every other cycle
    input wire logic        restart,             // new command
    input wire logic [7:0]  fail_at,             // failing sector, 0 for the 256th
    input wire logic        fail_idn,            // failure kind
    output logic [15:0]     n_bad                // words out of order
);
    logic [7:0] cnt;
    logic [7:0] sec;
    logic [2:0] hold;
    logic       tog;

    // The hold after each sector keeps stray words of a flushed buffer out.
    assign media_ready = hold == 3'h0 && (!slow || tog);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {cnt, sec, hold, tog, n_bad} <= '0;
            {media_done, media_uncorrectable, media_id_missing} <= 3'h0;
        end else begin
            tog <= !tog;
            {media_done, media_uncorrectable, media_id_missing} <= 3'h0;
            if (hold != 3'h0) hold <= hold - 3'h1;
            if (restart) sec <= 8'h00;
            if (media_valid && media_ready) begin
                if (media_word !== {8'ha5, cnt}) n_bad <= n_bad + 16'h1;
                cnt <= cnt + 8'h1;
                if (cnt == 8'hff) begin
                    hold       <= 3'h4;
                    media_done <= 1'b1;
                    sec        <= sec + 8'h1;
                    if (sec + 8'h1 == fail_at) begin
                        media_uncorrectable <= !fail_idn;
                        media_id_missing    <= fail_idn;
                    end
                end
            end
        end
    end
endmodule : wsc_media_model

// File: dv/testbench.sv
// Self-checking bench for the sector write command handler.
module testbench
    import wsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk, reset, tf_write, tf_read, auto_reassign, media_fault;
    logic        slow, restart, fail_idn, data_request, data_ready, busy, cmd_done;
    logic        media_valid, media_ready, media_lba_mode, media_done;
    logic        media_uncorrectable, media_id_missing;
    logic [2:0]  tf_addr;
    logic [7:0]  fail_at;
    logic [15:0] tf_wdata, tf_rdata, media_word, n_bad;
    logic [27:0] media_address;
    logic        saw_full = 1'b0;
    int          n_mismatch = 0, comparisons = 0, n_done = 0;

    wsc_handler u_dut (.core_clk(core_clk), .reset(reset), .tf_addr(tf_addr),
        .tf_write(tf_write), .tf_read(tf_read), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
        .data_request(data_request), .data_ready(data_ready), .busy(busy),
        .cmd_done(cmd_done), .media_word(media_word), .media_valid(media_valid),
        .media_ready(media_ready), .media_address(media_address),
        .media_lba_mode(media_lba_mode), .media_done(media_done),
        .media_uncorrectable(media_uncorrectable), .media_id_missing(media_id_missing),
        .media_fault(media_fault), .auto_reassign(auto_reassign));

    wsc_media_model u_media (.core_clk(core_clk), .reset(reset), .media_word(media_word),
        .media_valid(media_valid), .media_ready(media_ready), .media_done(media_done),
        .media_uncorrectable(media_uncorrectable), .media_id_missing(media_id_missing),
        .slow(slow), .restart(restart), .fail_at(fail_at), .fail_idn(fail_idn),
        .n_bad(n_bad));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (cmd_done === 1'b1) n_done <= n_done + 1;
        if (data_request === 1'b1 && data_ready === 1'b0) saw_full <= 1'b1;
    end

    task automatic check(input string name, input logic [27:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge core_clk);
        tf_addr  = a;
        tf_wdata = d;
        tf_write = 1'b1;
        @(negedge core_clk);
        tf_write = 1'b0;
    endtask : wr

    task automatic chk_reg(input logic [2:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        tf_addr = a;
        tf_read = 1'b1;
        @(negedge core_clk);
        tf_read = 1'b0;
        check($sformatf("register %0d", a), tf_rdata, exp);
    endtask : chk_reg

    task automatic push(input int n, d0);
        int w;
        w = 0;
        while (w < n && n_done == d0) begin
            @(negedge core_clk);
            if (data_request === 1'b1 && data_ready === 1'b1) begin
                tf_addr  = REG_DATA;
                tf_wdata = {8'ha5, w[7:0]};
                tf_write = 1'b1;
                w++;
            end else tf_write = 1'b0;
        end
        @(negedge core_clk);
        tf_write = 1'b0;
    endtask : push

    task automatic run_cmd(input logic [7:0] c, lo, mi, hi, dv, op, input int nw);
        int d0, g;
        d0 = n_done;
        restart = 1'b1;
        @(negedge core_clk);
        restart = 1'b0;
        wr(REG_COUNT, {8'h00, c});
        wr(REG_LOW, {8'h00, lo});
        wr(REG_MID, {8'h00, mi});
        wr(REG_HIGH, {8'h00, hi});
        wr(REG_DEVICE, {8'h00, dv});
        wr(REG_COMMAND, {8'h00, op});
        push(nw, d0);
        g = 0;
        while (n_done == d0 && g < 3000) begin
            @(negedge core_clk);
            g++;
        end
        check("command end", {27'h0, n_done != d0}, 28'h1);
    endtask : run_cmd

    task automatic t_reset;
        chk_reg(REG_COUNT, 16'h0001);
        chk_reg(REG_LOW, 16'h0001);
        chk_reg(REG_MID, 16'h0000);
        chk_reg(REG_HIGH, 16'h0000);
        chk_reg(REG_DEVICE, 16'h0000);
        chk_reg(REG_FEATURE, 16'h0000);
        chk_reg(REG_COMMAND, 16'h0050);
        media_fault = 1'b1;
        chk_reg(REG_COMMAND, 16'h0070);
        media_fault = 1'b0;
    endtask : t_reset

    task automatic t_lba;
        slow = 1'b1;
        run_cmd(8'h02, 8'hff, 8'h20, 8'h30, 8'h45, 8'h31, 512);
        check("address", media_address, 28'h5302100);
        check("mode", media_lba_mode, 28'h1);
        check("order", n_bad, 28'h0);
        check("full", saw_full, 28'h1);
        chk_reg(REG_COUNT, 16'h0000);
        chk_reg(REG_LOW, 16'h0000);
        chk_reg(REG_MID, 16'h0021);
        chk_reg(REG_HIGH, 16'h0030);
        chk_reg(REG_DEVICE, 16'h0045);
        chk_reg(REG_FEATURE, 16'h0000);
        chk_reg(REG_COMMAND, 16'h0050);
        slow = 1'b0;
    endtask : t_lba

    task automatic t_chs;
        run_cmd(8'h01, 8'h07, 8'h02, 8'h00, 8'ha3, 8'h30, 256);
        check("address", media_address, 28'h3000207);
        check("mode", media_lba_mode, 28'h0);
        chk_reg(REG_COUNT, 16'h0000);
        chk_reg(REG_LOW, 16'h0007);
        chk_reg(REG_DEVICE, 16'h0003);
    endtask : t_chs

    // A zero count asks for 256 sectors; the second one fails.
    task automatic t_fail;
        fail_at = 8'h02;
        run_cmd(8'h00, 8'hfe, 8'h00, 8'h00, 8'h40, 8'h30, 65536);
        chk_reg(REG_COUNT, 16'h00ff);
        chk_reg(REG_LOW, 16'h00ff);
        chk_reg(REG_FEATURE, 16'h0004);
        chk_reg(REG_COMMAND, 16'h0051);
    endtask : t_fail

    task automatic t_reassign;
        auto_reassign = 1'b1;
        fail_at = 8'h01;
        run_cmd(8'h02, 8'h00, 8'h00, 8'h00, 8'h40, 8'h31, 512);
        chk_reg(REG_COUNT, 16'h0000);
        chk_reg(REG_LOW, 16'h0001);
        chk_reg(REG_COMMAND, 16'h0050);
        auto_reassign = 1'b0;
    endtask : t_reassign

    task automatic t_idn_abort;
        fail_idn = 1'b1;
        run_cmd(8'h01, 8'h10, 8'h00, 8'h00, 8'h40, 8'h30, 256);
        chk_reg(REG_COUNT, 16'h0001);
        chk_reg(REG_FEATURE, 16'h0010);
        fail_at = 8'h00;
        run_cmd(8'h01, 8'h10, 8'h00, 8'h00, 8'h40, 8'h20, 0);
        chk_reg(REG_FEATURE, 16'h0014);
        chk_reg(REG_COMMAND, 16'h0051);
    endtask : t_idn_abort

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    initial begin
        {reset, tf_write, tf_read, auto_reassign, media_fault} = 5'h10;
        {slow, restart, fail_idn, fail_at, tf_addr, tf_wdata} = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        t_reset;
        t_lba;
        t_chs;
        t_fail;
        t_reassign;
        t_idn_abort;
        stop_test;
    end

    // About seven times the expected run length.
    initial begin
        #400000;
        n_mismatch++;
        stop_test;
    end
endmodule : testbench
